/* File: design/esbt_pkg.sv */
// Package: constants and carrier types for the exception syndrome unit
// How it works
// - Instruction bus error sets detail bit 20/52 on local bus error.
// - Data bus error sets detail bit 20/52 on local bus error.
// - Divide exception writes bit 20/52: 0 zero divisor, 1 overflow.
// - Stream exception stores link index in bits 23..26/55..58.
// - Data storage sets bit 20/52 when zone protection caused it.
// - Data storage sets bit 21/53 when the access was a store.
// - Instruction storage sets bit 20/52 on zone protection fault.
// - Data TLB miss sets bit 21/53 when the access was a store.
// - Detail field sits at 20..26 or 52..58 by data width.
// - Branch target register exists only when exceptions are configured.
// - Delay-slot branch with no exception in progress loads its target.
// - Special read selector 0x000B returns the branch target register.
// - Branch target width 32, or address width in 64-bit mode.
// - Branch target register resets to zero and is read-only.
// - Cause is a five-bit code; detail bits follow that code.
// - Delay-slot flag set when excepting instruction sat in a slot.
package esbt_pkg;

    // ************************************************************
    // Cause codes
    // ************************************************************
    localparam logic [4:0] EC_STREAM = 5'h00;
    localparam logic [4:0] EC_UNALIGNED = 5'h01;
    localparam logic [4:0] EC_ILLEGAL = 5'h02;
    localparam logic [4:0] EC_IBUS = 5'h03;
    localparam logic [4:0] EC_DBUS = 5'h04;
    localparam logic [4:0] EC_DIVIDE = 5'h05;
    localparam logic [4:0] EC_FPU = 5'h06;
    localparam logic [4:0] EC_PRIV = 5'h07;
    localparam logic [4:0] EC_DSTORAGE = 5'h10;
    localparam logic [4:0] EC_ISTORAGE = 5'h11;
    localparam logic [4:0] EC_DTLB = 5'h12;
    localparam logic [4:0] EC_ITLB = 5'h13;

    // ************************************************************
    // Field layout and selectors
    // ************************************************************
    localparam logic [13:0] SEL_STATUS = 14'h0005;
    localparam logic [13:0] SEL_BRANCH_TARGET = 14'h000B;
    localparam int CODE_LSB = 0; // Cause code lsb in LSB-0 numbering
    localparam int DETAIL_LSB = 5; // Detail field occupies [11:5]
    localparam int DSLOT_BIT = 12; // Delay-slot flag
    localparam int DETAIL_W = 7;
    localparam int LINK_W = 4;
    localparam int BIT_FLAG0 = 6; // Detail msb side: bit 20/52
    localparam int BIT_FLAG1 = 5; // Bit 21/53
    localparam logic [6:0] DETAIL_ZERO = 7'h00;
    localparam int CODE_W = 5; // Cause code width
    localparam logic [4:0] CODE_ZERO = 5'h00; // Cause code after reset

    // Exception report from the pipeline
    typedef struct packed {
        logic take;          // Exception taken this cycle
        logic [4:0] cause_code;
        logic delay_slot;    // Excepting instruction in a delay slot
        logic bus_ecc;       // Local memory bus error seen
        logic div_overflow;  // 1 overflow, 0 divide by zero
        logic [3:0] stream_link_index;
        logic zone_violation;
        logic is_store;
    } esbt_exc_t;

endpackage

/* File: design/esbt_unit.sv */
// Exception detail capture and delay-slot branch target register
`timescale 1ns/100ps
`default_nettype none
module esbt_unit #(
    parameter int DATA_SIZE = 32,
    parameter int ADDR_SIZE = 32,
    parameter bit USE_EXCEPTIONS = 1'b1
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Exception report
    input wire esbt_pkg::esbt_exc_t exc_i,
    // Branch events
    input wire logic branch_ds_i,
    input wire logic [ADDR_SIZE-1:0] branch_target_i,
    input wire logic exception_in_progress_i,
    // Special register read
    input wire logic move_from_special_i,
    input wire logic [13:0] special_reg_selector_i,
    output logic [DATA_SIZE-1:0] read_data_o,
    output logic read_valid_o,
    // Status view
    output logic [DATA_SIZE-1:0] exception_status_reg_o,
    output logic [ADDR_SIZE-1:0] branch_target_reg_o
);

    // ************************************************************
    // Detail encoding
    // ************************************************************
    // Build the 7-bit detail word for a cause (bit 6 = doc bit 20)
    function automatic logic [6:0] detail_of(input esbt_pkg::esbt_exc_t e);
        logic [6:0] d;
        // Start from all zero, then fill per cause
        d = esbt_pkg::DETAIL_ZERO;
        case (e.cause_code)
            esbt_pkg::EC_IBUS, esbt_pkg::EC_DBUS: begin
                d[esbt_pkg::BIT_FLAG0] = e.bus_ecc;
            end
            esbt_pkg::EC_DIVIDE: begin
                d[esbt_pkg::BIT_FLAG0] = e.div_overflow;
            end
            esbt_pkg::EC_STREAM: begin
                d[esbt_pkg::LINK_W-1:0] = e.stream_link_index;
            end
            esbt_pkg::EC_DSTORAGE: begin
                d[esbt_pkg::BIT_FLAG0] = e.zone_violation;
                d[esbt_pkg::BIT_FLAG1] = e.is_store;
            end
            esbt_pkg::EC_ISTORAGE: begin
                d[esbt_pkg::BIT_FLAG0] = e.zone_violation;
            end
            esbt_pkg::EC_DTLB: begin
                d[esbt_pkg::BIT_FLAG1] = e.is_store;
            end
            default: begin
                d = esbt_pkg::DETAIL_ZERO;
            end
        endcase
        return d;
    endfunction

    // ************************************************************
    // Status capture
    // ************************************************************
    logic [4:0] code_q, code_d;
    logic [6:0] detail_q, detail_d;
    logic dslot_q, dslot_d;
    // Status word, LSB-0 view
    logic [DATA_SIZE-1:0] status_word;

    // ************************************************************
    // Next-state selection
    // ************************************************************
    // replace on exception taken
    assign code_d = exc_i.take ? exc_i.cause_code : code_q;
    assign detail_d = exc_i.take ? detail_of(exc_i) : detail_q;
    assign dslot_d = exc_i.take ? exc_i.delay_slot : dslot_q;

    // Cause code register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            code_q <= esbt_pkg::CODE_ZERO;
        end else begin
            code_q <= code_d;
        end
    end

    // Detail field register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            detail_q <= esbt_pkg::DETAIL_ZERO;
        end else begin
            detail_q <= detail_d;
        end
    end

    // Delay-slot flag register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            dslot_q <= 1'b0;
        end else begin
            dslot_q <= dslot_d;
        end
    end

    // ************************************************************
    // Field placement
    // ************************************************************
    // field placement, LSB-0 view of big-endian numbering
    always_comb begin
        status_word = '0;
        status_word[esbt_pkg::CODE_LSB +: esbt_pkg::CODE_W] = code_q;
        status_word[esbt_pkg::DETAIL_LSB +: esbt_pkg::DETAIL_W] = detail_q;
        status_word[esbt_pkg::DSLOT_BIT] = dslot_q;
    end

    // ************************************************************
    // Branch target register
    // ************************************************************
    // target width by data size
    localparam int BT_W = (DATA_SIZE == 64) ? ADDR_SIZE : 32;
    logic [BT_W-1:0] bt_q;
    // Target in low bits, upper bits read zero
    logic [DATA_SIZE-1:0] bt_word;

    generate
        if (USE_EXCEPTIONS) begin : g_bt
            // load on delay-slot branch, reset zero
            always_ff @(posedge core_clk_i) begin
                if (rst_i) begin
                    bt_q <= '0;
                end else if (branch_ds_i && !exception_in_progress_i) begin
                    bt_q <= branch_target_i[BT_W-1:0]; // width
                end
            end
        end else begin : g_no_bt
            assign bt_q = '0;
        end
    endgenerate

    // Zero-extend target into the data word
    always_comb begin
        bt_word = '0;
        bt_word[BT_W-1:0] = bt_q;
    end

    // ************************************************************
    // Special register read port
    // ************************************************************
    // Selector matches
    wire hit_bt = special_reg_selector_i == esbt_pkg::SEL_BRANCH_TARGET;
    wire hit_st = special_reg_selector_i == esbt_pkg::SEL_STATUS;
    // branch target reads zero without exceptions
    wire sel_bt = hit_bt && USE_EXCEPTIONS;
    wire sel_st = hit_st;
    wire [DATA_SIZE-1:0] rd_mux = sel_bt ? bt_word :
                                  sel_st ? status_word : '0;

    // ************************************************************
    // Read port registers
    // ************************************************************
    // Read data holds until the next request
    wire read_req = move_from_special_i;
    wire [DATA_SIZE-1:0] read_data_d = read_req ? rd_mux : read_data_o;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            read_data_o <= '0;
        end else begin
            read_data_o <= read_data_d;
        end
    end

    // Read valid, one cycle after request
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            read_valid_o <= 1'b0;
        end else begin
            read_valid_o <= read_req;
        end
    end

    // ************************************************************
    // Status mirror register
    // ************************************************************
    // status view, one cycle behind
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            exception_status_reg_o <= '0;
        end else begin
            exception_status_reg_o <= status_word;
        end
    end

    // ************************************************************
    // Branch target mirror register
    // ************************************************************
    // branch target view, one cycle behind
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            branch_target_reg_o <= '0;
        end else begin
            branch_target_reg_o <= ADDR_SIZE'(bt_word);
        end
    end

endmodule
`default_nettype wire

/* File: testbench/esbt_chk.sv */
// Checker: port assertions for the exception syndrome unit
`timescale 1ns/100ps
`default_nettype none
module esbt_chk #(
    parameter int DATA_SIZE = 32,
    parameter int ADDR_SIZE = 32
) (
    // Clock, reset and inputs
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire esbt_pkg::esbt_exc_t exc_i,
    input wire logic branch_ds_i,
    input wire logic [ADDR_SIZE-1:0] branch_target_i,
    input wire logic exception_in_progress_i,
    input wire logic move_from_special_i,
    input wire logic [13:0] special_reg_selector_i,
    // Outputs
    input wire logic [DATA_SIZE-1:0] read_data_o,
    input wire logic read_valid_o,
    input wire logic [DATA_SIZE-1:0] exception_status_reg_o,
    input wire logic [ADDR_SIZE-1:0] branch_target_reg_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    wire logic [12:0] st_w = exception_status_reg_o[12:0];
    // Expected detail field for a report
    function automatic logic [6:0] ed(esbt_pkg::esbt_exc_t e);
        case (e.cause_code)
            esbt_pkg::EC_IBUS, esbt_pkg::EC_DBUS: ed = {e.bus_ecc, 6'h00};
            esbt_pkg::EC_DIVIDE: ed = {e.div_overflow, 6'h00};
            esbt_pkg::EC_STREAM: ed = {3'h0, e.stream_link_index};
            esbt_pkg::EC_DSTORAGE: ed = {e.zone_violation, e.is_store, 5'h00};
            esbt_pkg::EC_ISTORAGE: ed = {e.zone_violation, 6'h00};
            esbt_pkg::EC_DTLB: ed = {1'h0, e.is_store, 5'h00};
            default: ed = 7'h00;
        endcase
    endfunction
    sequence s_rd(s);
        move_from_special_i && special_reg_selector_i == s;
    endsequence
    sequence s_br;
        branch_ds_i && !exception_in_progress_i;
    endsequence
    property p_rd_valid;
        read_valid_o == $past(move_from_special_i);
    endproperty
    property p_rd_btr;
        s_rd(14'h000B) |=> read_data_o == DATA_SIZE'(branch_target_reg_o);
    endproperty
    property p_rd_st;
        s_rd(14'h0005) |=> read_data_o == exception_status_reg_o;
    endproperty
    property p_rd_bad;
        move_from_special_i && special_reg_selector_i != 14'h0005 &&
            special_reg_selector_i != 14'h000B |=> read_data_o == '0;
    endproperty
    property p_btr_cap;
        s_br |=> ##1 branch_target_reg_o == $past(branch_target_i, 2);
    endproperty
    property p_btr_hold;
        !(branch_ds_i && !exception_in_progress_i) |=> ##1
            $stable(branch_target_reg_o);
    endproperty
    property p_detail;
        exc_i.take |=> ##1 st_w[11:5] == ed($past(exc_i, 2));
    endproperty
    property p_code_ds;
        exc_i.take |=> ##1 st_w[4:0] == $past(exc_i.cause_code, 2) &&
            st_w[12] == $past(exc_i.delay_slot, 2);
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("bad valid");
    a_rd_btr: assert property (p_rd_btr) else $error("bad btr read");
    a_rd_st: assert property (p_rd_st) else $error("bad status read");
    a_rd_bad: assert property (p_rd_bad) else $error("bad sel read");
    a_btr_cap: assert property (p_btr_cap) else $error("no capture");
    a_btr_hold: assert property (p_btr_hold) else $error("btr moved");
    a_detail: assert property (p_detail) else $error("bad detail");
    a_code_ds: assert property (p_code_ds) else $error("bad code");
endmodule
bind esbt_unit esbt_chk #(.DATA_SIZE(DATA_SIZE), .ADDR_SIZE(ADDR_SIZE))
    esbt_chk_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .exc_i(exc_i),
    .branch_ds_i(branch_ds_i), .branch_target_i(branch_target_i),
    .exception_in_progress_i(exception_in_progress_i),
    .move_from_special_i(move_from_special_i),
    .special_reg_selector_i(special_reg_selector_i),
    .read_data_o(read_data_o), .read_valid_o(read_valid_o),
    .exception_status_reg_o(exception_status_reg_o),
    .branch_target_reg_o(branch_target_reg_o));
`default_nettype wire

/* File: testbench/exception_syndrome_branch_target_bench.sv */
// Bench: detail rows, branch target capture and reset
`timescale 1ns/100ps
`default_nettype none
module exception_syndrome_branch_target_bench;
    logic core_clk_i, rst_i, bds, exception_in_progress, mv, rd_v;
    esbt_pkg::esbt_exc_t exc;
    logic [31:0] bt, rd_data, st_o, bt_o;
    logic [13:0] sel;
    logic [26:0] rows [15];
    int miscompares = 0;
    int samples_checked = 0;
    esbt_unit esbt_unit_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .exc_i(exc), .branch_ds_i(bds), .branch_target_i(bt),
        .exception_in_progress_i(exception_in_progress), .move_from_special_i(mv),
        .special_reg_selector_i(sel), .read_data_o(rd_data),
        .read_valid_o(rd_v), .exception_status_reg_o(st_o),
        .branch_target_reg_o(bt_o));
    initial begin
        core_clk_i = 0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            miscompares++;
            $display("FAIL %0t got %h want %h", $time, g, x);
        end
    endtask
    // Special register read, checked one cycle on
    task automatic rd(input logic [13:0] s, input logic [31:0] x);
        @(posedge core_clk_i);
        mv <= 1;
        sel <= s;
        @(posedge core_clk_i);
        mv <= 0;
        @(negedge core_clk_i);
        chk({31'h0, rd_v}, 32'h1);
        chk(rd_data, x);
    endtask
    // One-cycle exception report
    task automatic ex(input esbt_pkg::esbt_exc_t e);
        @(posedge core_clk_i);
        exc <= e;
        @(posedge core_clk_i);
        exc.take <= 0;
    endtask
    // Branch event, target t, in-progress flag p
    task automatic br(input logic [31:0] t, input logic p);
        @(posedge core_clk_i);
        bds <= 1;
        bt <= t;
        exception_in_progress <= p;
        @(posedge core_clk_i);
        bds <= 0;
        exception_in_progress <= 0;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        tally_and_finish;
    end
    // Rows: cause, flags {ds,ecc,ovf,idx,zone,store}, status {ds,detail,code}
    initial begin
        rows = '{{esbt_pkg::EC_IBUS, 9'h083, 13'h0803},
            {esbt_pkg::EC_DBUS, 9'h180, 13'h1804},
            {esbt_pkg::EC_DIVIDE, 9'h080, 13'h0005},
            {esbt_pkg::EC_DIVIDE, 9'h040, 13'h0805},
            {esbt_pkg::EC_STREAM, 9'h03E, 13'h01E0},
            {esbt_pkg::EC_STREAM, 9'h014, 13'h00A0},
            {esbt_pkg::EC_DSTORAGE, 9'h003, 13'h0C10},
            {esbt_pkg::EC_DSTORAGE, 9'h001, 13'h0410},
            {esbt_pkg::EC_ISTORAGE, 9'h003, 13'h0811},
            {esbt_pkg::EC_DTLB, 9'h003, 13'h0412},
            {esbt_pkg::EC_ILLEGAL, 9'h1FF, 13'h1002},
            {esbt_pkg::EC_FPU, 9'h0FF, 13'h0006},
            {esbt_pkg::EC_PRIV, 9'h0FF, 13'h0007},
            {esbt_pkg::EC_ITLB, 9'h0FF, 13'h0013},
            {esbt_pkg::EC_UNALIGNED, 9'h0FF, 13'h0001}};
        rst_i = 1;
        exc = '0;
        {bds, exception_in_progress, mv, bt, sel} = '0;
        repeat (20) @(posedge core_clk_i);
        rst_i <= 0;
        rd(14'h000B, 32'h0);
        for (int i = 0; i < 15; i++) begin
            ex({1'h1, rows[i][26:13]});
            rd(14'h0005, {19'h0, rows[i][12:0]});
        end
        br(32'hA5A50F0C, 1'h0);
        rd(14'h000B, 32'hA5A50F0C);
        br(32'h12345678, 1'h1);
        rd(14'h000B, 32'hA5A50F0C);
        chk(bt_o, 32'hA5A50F0C);
        rd(14'h0003, 32'h0);
        @(posedge core_clk_i);
        rst_i <= 1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 0;
        rd(14'h000B, 32'h0);
        chk(st_o, 32'h0);
        tally_and_finish;
    end
endmodule
`default_nettype wire
